// [src/rtc_defs.vh]
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W              20
`define FRACTION_LO_ADDR    20'hFFF90
`define FRACTION_HI_ADDR    20'hFFF91
`define ONE_HZ_ADDR         20'hFFF92

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define FRACTION_W          16
`define FRACTION_RST        16'h0000
`define FRACTION_WRAP       16'h7FFF
`define FRACTION_TOP        16'hFFFF
`define ONE_HZ_W            8
`define ONE_HZ_RST          8'h00
`define BCD_LAST_SECOND     7'h59

// ----------------------------------------------------------------
// Field positions of one_hz_tally
// ----------------------------------------------------------------
`define UNITS_WEIGHT_ONE    0
`define UNITS_WEIGHT_EIGHT  3
`define TENS_WEIGHT_TEN     4
`define TENS_WEIGHT_FORTY   6
`define ONE_HZ_ZERO_BIT     7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SUB_CLK_HZ          32768
`define MCLK_HZ             40000000
`define COPY_LIMIT_TICKS    2
`define SYNC_STAGES         3

`endif

// [src/bcd_sec_step.v]
`timescale 1ns/1ps
`include "rtc_defs.vh"

// ----------------------------------------------------------------
// One BCD seconds step, 00..59 with wrap
// ----------------------------------------------------------------
module bcd_sec_step (
  input  wire [6:0] CUR,
  output reg  [6:0] NXT,
  output reg        WRAP
);

  wire [2:0] tens;
  wire [3:0] units;
  wire       legal;

  assign tens  = CUR[`TENS_WEIGHT_FORTY:`TENS_WEIGHT_TEN];
  assign units = CUR[`UNITS_WEIGHT_EIGHT:`UNITS_WEIGHT_ONE];
  assign legal = (tens <= 3'h5) && (units <= 4'h9);

  always @* begin
    NXT  = 7'h00;
    WRAP = 1'b0;
    if (!legal) begin
      // Illegal code falls back to zero on the very next step, no carry
      NXT = 7'h00;
    end else if (CUR == `BCD_LAST_SECOND) begin
      NXT  = 7'h00;
      WRAP = 1'b1;
    end else if (units == 4'h9) begin
      NXT = {tens + 3'h1, 4'h0};
    end else begin
      NXT = {tens, units + 4'h1};
    end
  end

endmodule // bcd_sec_step

// [src/rtc_seconds_counter.v]
// What this block does
// - A 16-bit sub-second counter advances on each 32.768 kHz tick through 0000H..7FFFH, one pass per second.
// - After a correction load the sub-second counter may hold 8000H or more and keeps counting.
// - Every write to the seconds register clears the sub-second counter to zero.
// - Reset clears the sub-second counter to 0000H.
// - The seconds register advances by one on each sub-second overflow.
// - A seconds write lands in a buffer and reaches the live count within 2 ticks of the 32.768 kHz clock.
// - An out-of-range seconds value returns to a legal count within one counting period.
// - Seconds bit 7 reads zero, bits 6..4 are the tens digit and bits 3..0 the units digit.
// - Reset clears the seconds register to 00H.
`timescale 1ns/1ps
`include "rtc_defs.vh"

module rtc_seconds_counter (
  input  wire                     MCLK,
  input  wire                     RST_B,
  input  wire                     SUB_CLK,
  input  wire [`ADDR_W-1:0]       CPU_ADDR,
  input  wire [`FRACTION_W-1:0]   CPU_WDATA,
  input  wire                     CPU_WR,
  input  wire                     CPU_RD,
  output reg  [`FRACTION_W-1:0]   CPU_RDATA,
  input  wire                     TRIM_LOAD,
  input  wire [`FRACTION_W-1:0]   TRIM_VALUE,
  output reg                      SUB_OVF,
  output reg                      MIN_CARRY,
  output wire [`ONE_HZ_W-1:0]     SECONDS
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam SEL_NONE     = 2'd0;
  localparam SEL_FRAC_LO  = 2'd1;
  localparam SEL_FRAC_HI  = 2'd2;
  localparam SEL_ONE_HZ   = 2'd3;

  localparam ST_IDLE      = 1'b0;
  localparam ST_PENDING   = 1'b1;

  // ----------------------------------------------------------------
  // Address decode, shared by the read and write paths
  // ----------------------------------------------------------------
  function [1:0] decode;
    input [`ADDR_W-1:0] addr;
    begin
      case (addr)
        `FRACTION_LO_ADDR: decode = SEL_FRAC_LO;
        `FRACTION_HI_ADDR: decode = SEL_FRAC_HI;
        `ONE_HZ_ADDR:      decode = SEL_ONE_HZ;
        default:           decode = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [`SYNC_STAGES-1:0]   sync_reg;
  reg                       sub_level_reg;
  reg                       sub_level_next;
  reg                       tick_reg;
  reg                       tick_next;

  reg  [`FRACTION_W-1:0]    fraction_tick_counter_reg;
  reg  [`FRACTION_W-1:0]    fraction_tick_counter_next;
  reg                       sub_ovf_next;

  reg  [6:0]                one_hz_tally_reg;
  reg  [6:0]                one_hz_tally_next;
  reg  [6:0]                hold_buf_reg;
  reg  [6:0]                hold_buf_next;
  reg                       copy_state_reg;
  reg                       copy_state_next;
  reg                       min_carry_next;

  reg  [`FRACTION_W-1:0]    rdata_next;

  wire [1:0]                wr_sel;
  wire [1:0]                rd_sel;
  wire                      sec_write;
  wire                      frac_at_wrap;
  wire [6:0]                step_value;
  wire                      step_wrap;

  assign wr_sel    = decode(CPU_ADDR);
  assign rd_sel    = decode(CPU_ADDR);
  assign sec_write = CPU_WR && (wr_sel == SEL_ONE_HZ);

  // ----------------------------------------------------------------
  // Sub-clock synchroniser
  // ----------------------------------------------------------------
  // Stage 0 feeds stage 1 only; the edge is judged on stages 1 and 2
  genvar g;
  generate
    for (g = 0; g < `SYNC_STAGES; g = g + 1) begin : g_sync
      if (g == 0) begin : g_first
        always @(posedge MCLK or negedge RST_B) begin
          if (!RST_B) begin
            sync_reg[0] <= 1'b0;
          end else begin
            sync_reg[0] <= SUB_CLK;
          end
        end
      end else begin : g_next
        // Later stages only; no stage below zero is ever referenced
        always @(posedge MCLK or negedge RST_B) begin
          if (!RST_B) begin
            sync_reg[g] <= 1'b0;
          end else begin
            sync_reg[g] <= sync_reg[g-1];
          end
        end
      end
    end
  endgenerate

  always @* begin
    sub_level_next = sub_level_reg;
    tick_next      = 1'b0;
    // A level counts only once two stages agree, so a glitch is dropped
    if (sync_reg[1] == sync_reg[2]) begin
      sub_level_next = sync_reg[2];
      tick_next      = sync_reg[2] && !sub_level_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sub-second counter
  // ----------------------------------------------------------------
  assign frac_at_wrap = (fraction_tick_counter_reg == `FRACTION_WRAP) ||
                        (fraction_tick_counter_reg == `FRACTION_TOP);

  always @* begin
    fraction_tick_counter_next = fraction_tick_counter_reg;
    sub_ovf_next               = 1'b0;
    if (sec_write) begin
      // A seconds write restarts the second from zero
      fraction_tick_counter_next = `FRACTION_RST;
    end else if (TRIM_LOAD) begin
      // Correction may park the count above the normal range
      fraction_tick_counter_next = TRIM_VALUE;
    end else if (tick_reg) begin
      if (frac_at_wrap) begin
        fraction_tick_counter_next = `FRACTION_RST;
        sub_ovf_next               = 1'b1;
      end else begin
        fraction_tick_counter_next = fraction_tick_counter_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Seconds stage
  // ----------------------------------------------------------------
  bcd_sec_step u_step (
    .CUR  (one_hz_tally_reg),
    .NXT  (step_value),
    .WRAP (step_wrap)
  );

  always @* begin
    one_hz_tally_next = one_hz_tally_reg;
    hold_buf_next     = hold_buf_reg;
    copy_state_next   = copy_state_reg;
    min_carry_next    = 1'b0;
    if (sec_write) begin
      // Range is the writer's duty; bad codes are repaired on the next step
      hold_buf_next   = CPU_WDATA[6:0];
      copy_state_next = ST_PENDING;
    end
    case (copy_state_reg)
      ST_IDLE: begin
        if (SUB_OVF) begin
          one_hz_tally_next = step_value;
          min_carry_next    = step_wrap;
        end
      end
      ST_PENDING: begin
        // Copy on the first tick after the write, well inside the limit
        if (!sec_write && tick_reg) begin
          one_hz_tally_next = hold_buf_reg;
          copy_state_next   = ST_IDLE;
        end
      end
      default: begin
        copy_state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Reads of the running counter are not coherent; software must stop
  // or re-read, the hardware does not latch a snapshot
  always @* begin
    rdata_next = CPU_RDATA;
    if (CPU_RD) begin
      case (rd_sel)
        SEL_FRAC_LO: rdata_next = fraction_tick_counter_reg;
        SEL_FRAC_HI: rdata_next = {8'h00, fraction_tick_counter_reg[15:8]};
        SEL_ONE_HZ:  rdata_next = {8'h00, SECONDS};
        default:     rdata_next = 16'h0000;
      endcase
    end
  end

  assign SECONDS = {1'b0, one_hz_tally_reg};

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      sub_level_reg             <= 1'b0;
      tick_reg                  <= 1'b0;
      fraction_tick_counter_reg <= `FRACTION_RST;
      SUB_OVF                   <= 1'b0;
      one_hz_tally_reg          <= 7'h00;
      hold_buf_reg              <= 7'h00;
      copy_state_reg            <= ST_IDLE;
      MIN_CARRY                 <= 1'b0;
      CPU_RDATA                 <= 16'h0000;
    end else begin
      sub_level_reg             <= sub_level_next;
      tick_reg                  <= tick_next;
      fraction_tick_counter_reg <= fraction_tick_counter_next;
      SUB_OVF                   <= sub_ovf_next;
      one_hz_tally_reg          <= one_hz_tally_next;
      hold_buf_reg              <= hold_buf_next;
      copy_state_reg            <= copy_state_next;
      MIN_CARRY                 <= min_carry_next;
      CPU_RDATA                 <= rdata_next;
    end
  end

endmodule // rtc_seconds_counter

// [bench/rtc_seconds_counter_chk.sv]
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_seconds_counter_chk (
  input wire logic                 MCLK,
  input wire logic                 RST_B,
  input wire logic [`ADDR_W-1:0]     CPU_ADDR,
  input wire logic                 CPU_WR,
  input wire logic                 CPU_RD,
  input wire logic [`FRACTION_W-1:0] CPU_RDATA,
  input wire logic                 SUB_OVF,
  input wire logic                 MIN_CARRY,
  input wire logic [`ONE_HZ_W-1:0]   SECONDS
);
  wire sec_wr = CPU_WR && (CPU_ADDR == `ONE_HZ_ADDR);
  wire sec_rd = CPU_RD && (CPU_ADDR == `ONE_HZ_ADDR);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  chk_bit7_zero: assert property (SECONDS[7] == 1'b0)
    else $error("seconds bit 7 set");
  chk_ovf_single: assert property (SUB_OVF |=> !SUB_OVF)
    else $error("overflow strobe longer than one cycle");
  chk_carry_single: assert property (MIN_CARRY |=> !MIN_CARRY)
    else $error("carry longer than one cycle");
  chk_carry_wrap: assert property (MIN_CARRY |-> SECONDS == 8'h00 && $past(SECONDS) == 8'h59 && $past(SUB_OVF))
    else $error("carry without 59 to 00 wrap");
  chk_wr_clears: assert property (sec_wr |=> !SUB_OVF [*8])
    else $error("overflow right after seconds write");
  chk_reset_clear: assert property ($rose(RST_B) |-> SECONDS == `ONE_HZ_RST && !SUB_OVF && !MIN_CARRY)
    else $error("outputs not clear after reset");
  chk_rd_seconds: assert property (sec_rd |=> CPU_RDATA == {8'h00, $past(SECONDS)})
    else $error("seconds read mismatch");
  chk_sec_legal: assert property (SUB_OVF |=> SECONDS[3:0] <= 4'h9 && SECONDS[6:4] <= 3'h5)
    else $error("illegal seconds after overflow");
endmodule // rtc_seconds_counter_chk

bind rtc_seconds_counter rtc_seconds_counter_chk rtc_seconds_counter_chk_i (
  .MCLK(MCLK), .RST_B(RST_B), .CPU_ADDR(CPU_ADDR), .CPU_WR(CPU_WR), .CPU_RD(CPU_RD),
  .CPU_RDATA(CPU_RDATA), .SUB_OVF(SUB_OVF), .MIN_CARRY(MIN_CARRY), .SECONDS(SECONDS));

// [bench/rtc_seconds_counter_test.sv]
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_seconds_counter_test;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sub_clk = 1'b0;
  logic        sub_en = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        trim = 1'b0;
  logic [15:0] trim_val = 16'h0000;
  logic [15:0] rdata;
  logic        sub_ovf;
  logic        min_carry;
  logic [7:0]  seconds;
  logic [15:0] got;
  int          bad_count = 0;
  int          n_checks = 0;
  int          n_rise = 0;
  int          r0 = 0;
  logic [15:0] row_w [0:3] = '{16'h0000, 16'h0059, 16'h00B0, 16'h0045};
  logic [7:0]  row_e [0:3] = '{8'h00, 8'h59, 8'h30, 8'h45};

  always #12.5 mclk = ~mclk;
  // Sped-up stand-in for the 32.768 kHz input; a whole second does not fit the run, so trim loads jump near overflow; parks low
  always begin
    #137;
    sub_clk = sub_en ? ~sub_clk : 1'b0;
  end
  // Rises offered to the block, the reference for the tick count
  always @(posedge sub_clk) n_rise++;

  rtc_seconds_counter rtc_seconds_counter_i (
    .MCLK(mclk), .RST_B(rst_b), .SUB_CLK(sub_clk), .CPU_ADDR(addr), .CPU_WDATA(wdata),
    .CPU_WR(wr), .CPU_RD(rd), .CPU_RDATA(rdata), .TRIM_LOAD(trim), .TRIM_VALUE(trim_val),
    .SUB_OVF(sub_ovf), .MIN_CARRY(min_carry), .SECONDS(seconds));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask
  task automatic bus_wr(input logic [19:0] a, input logic [15:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic bus_rd(input logic [19:0] a);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    got = rdata;
  endtask
  task automatic load_trim(input logic [15:0] v);
    @(negedge mclk);
    trim_val = v;
    trim = 1'b1;
    @(negedge mclk);
    trim = 1'b0;
  endtask
  // Returns just after the edge on which seconds reacts to the strobe
  task automatic wait_ovf();
    int k;
    k = 0;
    while (sub_ovf !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check({15'h0000, sub_ovf}, 16'h0001, "ovf");
    @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    bus_rd(`FRACTION_LO_ADDR);
    check(got, `FRACTION_RST, "frac rst");
    bus_rd(`ONE_HZ_ADDR);
    check(got, 16'h0000, "sec rst");
    sub_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      load_trim(16'h1234);
      bus_wr(`ONE_HZ_ADDR, row_w[i]);
      repeat (28) @(negedge mclk);
      check({8'h00, seconds}, {8'h00, row_e[i]}, "copy");
      bus_rd(`ONE_HZ_ADDR);
      check(got, {8'h00, row_e[i]}, "sec rd");
      bus_rd(`FRACTION_LO_ADDR);
      check({15'h0000, got < 16'h0008}, 16'h0001, "frac clr");
    end
    bus_wr(`ONE_HZ_ADDR, 16'h0058);
    repeat (28) @(negedge mclk);
    load_trim(16'h7FFE);
    wait_ovf();
    check({8'h00, seconds}, 16'h0059, "step");
    load_trim(16'h7FFE);
    wait_ovf();
    check({7'h00, min_carry, seconds}, 16'h0100, "wrap");
    sub_en = 1'b0;
    repeat (10) @(negedge mclk);
    bus_rd(`FRACTION_LO_ADDR);
    check({15'h0000, got < 16'h0003}, 16'h0001, "frac wrap");
    // Counter stopped, so the read is exact: one step per rise offered
    load_trim(16'h0100);
    r0 = n_rise;
    sub_en = 1'b1;
    repeat (60) @(negedge mclk);
    sub_en = 1'b0;
    repeat (10) @(negedge mclk);
    bus_rd(`FRACTION_LO_ADDR);
    check(got, 16'h0100 + 16'(n_rise - r0), "tick count");
    load_trim(16'hFFFE);
    bus_rd(`FRACTION_LO_ADDR);
    check(got, 16'hFFFE, "above 7FFF");
    sub_en = 1'b1;
    wait_ovf();
    check({8'h00, seconds}, 16'h0001, "step2");
    // Reset in mid-run must clear both counters
    @(negedge mclk);
    rst_b = 1'b0;
    sub_en = 1'b0;
    repeat (10) @(negedge mclk);
    check({8'h00, seconds}, 16'h0000, "sec rst2");
    rst_b = 1'b1;
    bus_rd(`FRACTION_LO_ADDR);
    check(got, 16'h0000, "frac rst2");
    sub_en = 1'b1;
    bus_wr(`ONE_HZ_ADDR, 16'h007A);
    repeat (28) @(negedge mclk);
    load_trim(16'h7FFE);
    wait_ovf();
    check({7'h00, min_carry, seconds}, 16'h0000, "illegal");
    print_verdict();
  end

  initial begin
    #500000;
    bad_count++;
    $display("ERROR %0t: watchdog", $time);
    print_verdict();
  end
endmodule // rtc_seconds_counter_test
